// File: rtl/fwp_pkg.sv
/*
 Shared constants and types for the flash write-permission gate:
 opcodes, status field positions, array geometry and command classes.
 Assumes the whole design runs on one 125 MHz system clock.
*/
package fwp_pkg;

	// Write-latch and program/erase opcodes
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_PROG      = 8'h02;
	localparam logic [7:0] OP_PROG4     = 8'h12;
	localparam logic [7:0] OP_QPROG     = 8'h32;
	localparam logic [7:0] OP_QPROG4    = 8'h34;
	localparam logic [7:0] OP_QIO_PROG  = 8'h38;
	localparam logic [7:0] OP_QIO_PROG4 = 8'h3E;
	localparam logic [7:0] OP_SE_A     = 8'hD7;
	localparam logic [7:0] OP_SE_B     = 8'h20;
	localparam logic [7:0] OP_SE4      = 8'h21;
	localparam logic [7:0] OP_BE32     = 8'h52;
	localparam logic [7:0] OP_BE32_4   = 8'h5C;
	localparam logic [7:0] OP_BE64     = 8'hD8;
	localparam logic [7:0] OP_BE64_4   = 8'hDC;
	localparam logic [7:0] OP_CE_A     = 8'hC7;
	localparam logic [7:0] OP_CE_B     = 8'h60;
	// Register write opcodes
	localparam logic [7:0] OP_SR_WR    = 8'h01;
	localparam logic [7:0] OP_FR_WR    = 8'h42;
	localparam logic [7:0] OP_RP_NV    = 8'h65;
	localparam logic [7:0] OP_RP_V     = 8'h63;
	localparam logic [7:0] OP_RP_V_ALT = 8'hC0;
	localparam logic [7:0] OP_ERP_NV   = 8'h85;
	localparam logic [7:0] OP_ERP_V    = 8'h83;
	localparam logic [7:0] OP_BANK_NV  = 8'h18;
	localparam logic [7:0] OP_BANK_V   = 8'hC5;
	localparam logic [7:0] OP_BANK_ALT = 8'h17;
	localparam logic [7:0] OP_DYN_A    = 8'hFB;
	localparam logic [7:0] OP_DYN_B    = 8'hE1;
	localparam logic [7:0] OP_PER_A    = 8'hFD;
	localparam logic [7:0] OP_PER_B    = 8'hE3;
	localparam logic [7:0] OP_TRN_NV   = 8'h43;
	localparam logic [7:0] OP_TRN_V    = 8'h4A;
	// Other write-gated non-volatile operations
	localparam logic [7:0] OP_IR_ER    = 8'h64;
	localparam logic [7:0] OP_IR_PG    = 8'h62;
	localparam logic [7:0] OP_AB_WR    = 8'h15;
	localparam logic [7:0] OP_PER_ER   = 8'hE4;
	localparam logic [7:0] OP_ASP_PG   = 8'h2F;
	localparam logic [7:0] OP_PLB_WR   = 8'hA6;
	localparam logic [7:0] OP_FRZ      = 8'h91;
	localparam logic [7:0] OP_GANG_LK  = 8'h7E;
	localparam logic [7:0] OP_GANG_UN  = 8'h98;
	localparam logic [7:0] OP_PWD_PG   = 8'hE8;
	// Write-disable opcode default
	localparam logic [7:0] OP_WR_DISABLE_DEF = 8'h04;

	// Status register layout and reset value
	localparam int         SR_WIP     = 0;
	localparam int         SR_LATCH   = 1;
	localparam int         SR_BP_LSB  = 2;
	localparam int         SR_QUAD    = 6;
	localparam int         SR_LOCK    = 7;
	localparam logic [7:0] SR_RESET   = 8'h00;
	localparam logic [3:0] BP_NONE    = 4'h0;

	// Array geometry: 1024 blocks of 64KB
	localparam int          BLK_LSB    = 16;
	localparam int          BLK_W      = 10;
	localparam int          ADDR3_W    = 24;
	localparam logic [10:0] ARRAY_BLKS = 11'h400;

	// Classification of one opcode
	typedef struct packed {
		logic known;
		logic write_enable_cmd;
		logic write_disable_cmd;
		logic gated;
		logic busy_op;
		logic addr_check;
		logic force_4b;
		logic chip_erase;
		logic status_write;
	} fwp_cmd_class_t;

	// Command strobe with its operands
	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [31:0] addr;
		logic [7:0]  sr_data;
	} fwp_cmd_t;

	typedef enum logic {fwp_st_idle, fwp_st_busy} fwp_state_t;

	// Builds a class for a write-gated or exempt opcode
	function automatic fwp_cmd_class_t fwp_mk(input logic gated, input logic busy_op,
		input logic addr_check, input logic force_4b);
		fwp_cmd_class_t c;
		c            = '0;
		c.known      = 1'b1;
		c.gated      = gated;
		c.busy_op    = busy_op;
		c.addr_check = addr_check;
		c.force_4b   = force_4b;
		return c;
	endfunction

	// Protected block count per block-protect code
	function automatic logic [10:0] fwp_prot_blocks(input logic [3:0] code);
		logic [10:0] n;
		n = 11'h000;
		unique case (code)
			4'h0: n = 11'h000;
			4'h1: n = 11'h001;
			4'h2: n = 11'h002;
			4'h3: n = 11'h004;
			4'h4: n = 11'h008;
			4'h5: n = 11'h010;
			4'h6: n = 11'h020;
			4'h7: n = 11'h040;
			4'h8: n = 11'h080;
			4'h9: n = 11'h100;
			4'hA: n = 11'h200;
			4'hB: n = 11'h300;
			4'hC: n = 11'h380;
			4'hD: n = 11'h3C0;
			4'hE: n = 11'h3E0;
			4'hF: n = 11'h400;
		endcase
		return n;
	endfunction

endpackage

// File: rtl/fwp_opcode_decode.sv
/*
 Opcode classifier for the write-permission gate.
 Purely combinational; the caller registers whatever it needs.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_opcode_decode #(
	parameter logic [7:0] WRITE_DISABLE_CMD_OPCODE = fwp_pkg::OP_WR_DISABLE_DEF
) (
	input  wire logic [7:0]              opcode_in, // Instruction byte
	output var  fwp_pkg::fwp_cmd_class_t class_out  // Its class
);
	fwp_pkg::fwp_cmd_class_t c;

	// Unknown opcodes (reads etc.) stay all-zero and pass untouched
	always_comb
	begin
		c = '0;
		unique case (opcode_in)
			fwp_pkg::OP_WR_ENABLE:
			begin
				c.known = 1'b1;
				c.write_enable_cmd  = 1'b1;
			end
			WRITE_DISABLE_CMD_OPCODE:
			begin
				c.known = 1'b1;
				c.write_disable_cmd  = 1'b1;
			end
			fwp_pkg::OP_PROG, fwp_pkg::OP_QPROG, fwp_pkg::OP_QIO_PROG:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b1, 1'b0);
			fwp_pkg::OP_PROG4, fwp_pkg::OP_QPROG4, fwp_pkg::OP_QIO_PROG4:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b1, 1'b1);
			fwp_pkg::OP_SE_A, fwp_pkg::OP_SE_B, fwp_pkg::OP_BE32, fwp_pkg::OP_BE64:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b1, 1'b0);
			fwp_pkg::OP_SE4, fwp_pkg::OP_BE32_4, fwp_pkg::OP_BE64_4:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b1, 1'b1);
			fwp_pkg::OP_CE_A, fwp_pkg::OP_CE_B:
			begin
				c            = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b0, 1'b0);
				c.chip_erase = 1'b1;
			end
			fwp_pkg::OP_SR_WR:
			begin
				c              = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b0, 1'b0);
				c.status_write = 1'b1;
			end
			fwp_pkg::OP_RP_NV, fwp_pkg::OP_ERP_NV, fwp_pkg::OP_BANK_NV, fwp_pkg::OP_TRN_NV,
			fwp_pkg::OP_PER_A, fwp_pkg::OP_FR_WR:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b0, 1'b0);
			fwp_pkg::OP_PER_B, fwp_pkg::OP_DYN_A:
				c = fwp_pkg::fwp_mk(1'b1, fwp_pkg::OP_PER_B == opcode_in, 1'b0, 1'b1);
			fwp_pkg::OP_RP_V, fwp_pkg::OP_ERP_V, fwp_pkg::OP_BANK_V, fwp_pkg::OP_TRN_V,
			fwp_pkg::OP_DYN_B:
				c = fwp_pkg::fwp_mk(1'b1, 1'b0, 1'b0, 1'b0);
			fwp_pkg::OP_RP_V_ALT, fwp_pkg::OP_BANK_ALT:
				c = fwp_pkg::fwp_mk(1'b0, 1'b0, 1'b0, 1'b0);
			fwp_pkg::OP_IR_ER, fwp_pkg::OP_IR_PG, fwp_pkg::OP_AB_WR, fwp_pkg::OP_PER_ER,
			fwp_pkg::OP_ASP_PG, fwp_pkg::OP_PLB_WR, fwp_pkg::OP_FRZ, fwp_pkg::OP_GANG_LK,
			fwp_pkg::OP_GANG_UN, fwp_pkg::OP_PWD_PG:
				c = fwp_pkg::fwp_mk(1'b1, 1'b1, 1'b0, 1'b0);
			default:
				c = '0;
		endcase
	end

	assign class_out = c;
endmodule
`default_nettype wire

// File: rtl/fwp_protect_range.sv
/*
 Block-protect range check: is a 64KB block inside the protected area
 selected by the block-protect code and top/bottom select.
 Combinational; block index already extracted by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_protect_range (
	input  wire logic [3:0] bp_code_in, // Block-protect code
	input  wire logic       top_bottom_select_in, // 0 top, 1 bottom
	input  wire logic [9:0] blk_idx_in, // Target 64KB block
	output logic            hit_out     // Block is protected
);
	logic [10:0] count;
	logic [10:0] blk_wide;
	logic        top_hit;
	logic        bot_hit;

	// Top area grows down from the last block, bottom area up from block 0
	assign count    = fwp_pkg::fwp_prot_blocks(bp_code_in);
	assign blk_wide = {1'b0, blk_idx_in};
	assign top_hit  = blk_wide >= (fwp_pkg::ARRAY_BLKS - count);
	assign bot_hit  = blk_wide < count;
	assign hit_out  = (count != 11'h000) & (top_bottom_select_in ? bot_hit : top_hit);
endmodule
`default_nettype wire

// File: rtl/fwp_gate.sv
/*
 Write-permission gate of a serial NOR flash command decoder.
 Decides whether each decoded instruction is accepted or refused and
 keeps the write-enable latch, busy flag and protection status bits.
 Assumes commands arrive already deserialised as one-cycle strobes,
 synchronous to clk_sys_in, and that the array engine pulses
 op_done_in when a busy operation finishes.
*/
// What this block does
// - Gated program, erase and register writes need a prior write-enable.
// - Page program 02h uses address mode; 12h always four-byte address.
// - Quad page program 32h/34h, quad address-data 38h/3Eh, all gated.
// - Sector erase D7h/20h mode address, 21h four-byte; gated.
// - 32KB block erase 52h mode address, 5Ch four-byte; gated.
// - 64KB block erase D8h mode address, DCh four-byte; gated.
// - Read-parameter writes 65h non-volatile, 63h volatile; gated.
// - Extended read-parameter writes 85h non-volatile, 83h volatile; gated.
// - Bank register writes 18h non-volatile, C5h volatile; gated.
// - Training pattern programs 43h non-volatile, 4Ah volatile; gated.
// - Dynamic sector lock writes FBh and E1h; gated.
// - Persistent sector lock writes FDh mode address, E3h four-byte; gated.
// - Alternates C0h and 17h are accepted without write-enable.
// - Four-bit protect code selects the protected part of the array.
// - Program or erase into a protected block is inhibited.
// - Chip erase C7h/60h ignored unless protect code is zero.
// - Status-write-disable clear lets status writes through regardless of pin.
// - Disable set with protect pin low and quad enable low freezes status bits, ignores writes.
// - Disable set with protect pin high still allows status writes.
// - Quad enable low keeps protect/hold pins; high makes them data lines.
// - Latch set by 06h, cleared by write-disable and on completion.
// - Protected block counts per code, from top or bottom by select.
`timescale 1ns/1ps
`default_nettype none
module fwp_gate #(
	parameter logic [7:0] WRITE_DISABLE_CMD_OPCODE = fwp_pkg::OP_WR_DISABLE_DEF
) (
	input  wire logic             clk_sys_in,           // 125 MHz system clock
	input  wire logic             rst_in,               // Sync reset, active high
	input  wire fwp_pkg::fwp_cmd_t cmd_in,              // Decoded command strobe
	input  wire logic             addr_mode_4b_in,      // Current 4-byte mode
	input  wire logic             wp_n_in,              // Protect pin, active low
	input  wire logic             top_bottom_select_in, // 0 top, 1 bottom area
	input  wire logic             op_done_in,           // Busy operation finished
	output logic                  accept_out,           // Command accepted pulse
	output logic                  refuse_out,           // Command refused pulse
	output var fwp_pkg::fwp_cmd_class_t accepted_class_out, // Class of last accepted
	output logic [31:0]           accepted_addr_out,    // Effective address
	output logic [7:0]            status_out,           // Status register image
	output logic                  write_enable_latch_out, // Latch state
	output logic                  busy_out,             // Operation in progress
	output logic                  quad_enable_out,      // Quad mode enabled
	output logic                  pin_func_enable_out   // Protect/hold pins live
);
	fwp_pkg::fwp_cmd_class_t cls;
	fwp_pkg::fwp_state_t     state_ff;
	fwp_pkg::fwp_state_t     nxt_state;
	logic                    latch_ff;
	logic                    nxt_latch;
	logic [3:0]              bp_ff;
	logic [3:0]              nxt_bp;
	logic                    quad_ff;
	logic                    nxt_quad;
	logic                    srlock_ff;
	logic                    nxt_srlock;
	logic                    busy_ff;
	logic                    accept_ff;
	logic                    refuse_ff;
	fwp_pkg::fwp_cmd_class_t acc_cls_ff;
	logic [31:0]             acc_addr_ff;
	logic                    pin_func_ff;
	logic [31:0]             eff_addr;
	logic                    range_hit;
	logic                    busy_now;
	logic                    sr_locked;
	logic                    no_latch;
	logic                    prot_block;
	logic                    ce_block;
	logic                    sr_block;
	logic                    refuse;
	logic                    accept;
	logic                    done_now;

	// Opcode classification
	fwp_opcode_decode #(
		.WRITE_DISABLE_CMD_OPCODE (WRITE_DISABLE_CMD_OPCODE)
	) u_decode (
		.opcode_in (cmd_in.opcode),
		.class_out (cls)
	);

	// Mode-dependent opcodes see only the low three bytes in 3-byte mode
	assign eff_addr = (cls.force_4b | addr_mode_4b_in) ? cmd_in.addr :
		{8'h00, cmd_in.addr[fwp_pkg::ADDR3_W-1:0]};

	// Protected-area check on the target block
	fwp_protect_range u_range (
		.bp_code_in           (bp_ff),
		.top_bottom_select_in (top_bottom_select_in),
		.blk_idx_in           (eff_addr[fwp_pkg::BLK_LSB +: fwp_pkg::BLK_W]),
		.hit_out              (range_hit)
	);

	// Refusal causes; busy refuses everything this gate knows about
	assign busy_now   = (state_ff == fwp_pkg::fwp_st_busy);
	assign sr_locked  = srlock_ff & ~wp_n_in & ~quad_ff;
	assign no_latch   = cls.gated & ~latch_ff;
	assign prot_block = cls.addr_check & range_hit;
	assign ce_block   = cls.chip_erase & (bp_ff != fwp_pkg::BP_NONE);
	assign sr_block   = cls.status_write & sr_locked;
	assign refuse     = cmd_in.valid & cls.known &
		(busy_now | no_latch | prot_block | ce_block | sr_block);
	assign accept     = cmd_in.valid & cls.known & ~refuse;
	assign done_now   = busy_now & op_done_in;

	// Busy state: a refused command never reaches it
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			fwp_pkg::fwp_st_idle:
				if (accept & cls.busy_op)
				begin
					nxt_state = fwp_pkg::fwp_st_busy;
				end
			fwp_pkg::fwp_st_busy:
				if (op_done_in)
				begin
					nxt_state = fwp_pkg::fwp_st_idle;
				end
		endcase
	end

	// Write-enable latch; commands are refused while busy, so set and
	// completion clear never meet in one cycle
	always_comb
	begin
		nxt_latch = latch_ff;
		if (done_now)
		begin
			nxt_latch = 1'b0;
		end
		if (accept & cls.write_disable_cmd)
		begin
			nxt_latch = 1'b0;
		end
		if (accept & cls.write_enable_cmd)
		begin
			nxt_latch = 1'b1;
		end
	end

	// Status bits written only by an accepted status write
	assign nxt_bp   = (accept & cls.status_write) ?
		cmd_in.sr_data[fwp_pkg::SR_BP_LSB +: 4] : bp_ff;
	assign nxt_quad   = (accept & cls.status_write) ? cmd_in.sr_data[fwp_pkg::SR_QUAD] : quad_ff;
	assign nxt_srlock = (accept & cls.status_write) ? cmd_in.sr_data[fwp_pkg::SR_LOCK] : srlock_ff;

	// Control and status registers
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_ff  <= fwp_pkg::fwp_st_idle;
			busy_ff   <= 1'b0;
			latch_ff  <= fwp_pkg::SR_RESET[fwp_pkg::SR_LATCH];
			bp_ff     <= fwp_pkg::SR_RESET[fwp_pkg::SR_BP_LSB +: 4];
			quad_ff   <= fwp_pkg::SR_RESET[fwp_pkg::SR_QUAD];
			srlock_ff <= fwp_pkg::SR_RESET[fwp_pkg::SR_LOCK];
		end
		else
		begin
			state_ff  <= nxt_state;
			busy_ff   <= (nxt_state == fwp_pkg::fwp_st_busy); // Output straight from a flop
			latch_ff  <= nxt_latch;
			bp_ff     <= nxt_bp;
			quad_ff   <= nxt_quad;
			srlock_ff <= nxt_srlock;
		end
	end

	// Result pulses and the captured accepted command
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			accept_ff   <= 1'b0;
			refuse_ff   <= 1'b0;
			acc_cls_ff  <= '0;
			acc_addr_ff <= 32'h0000_0000;
			pin_func_ff <= 1'b1;
		end
		else
		begin
			accept_ff   <= accept;
			refuse_ff   <= refuse;
			pin_func_ff <= ~nxt_quad;
			if (accept)
			begin
				acc_cls_ff  <= cls;
				acc_addr_ff <= eff_addr;
			end
		end
	end

	assign accept_out             = accept_ff;
	assign refuse_out             = refuse_ff;
	assign accepted_class_out     = acc_cls_ff;
	assign accepted_addr_out      = acc_addr_ff;
	assign status_out             = {srlock_ff, quad_ff, bp_ff, latch_ff, busy_ff};
	assign write_enable_latch_out = latch_ff;
	assign busy_out               = busy_ff;
	assign quad_enable_out        = quad_ff;
	assign pin_func_enable_out    = pin_func_ff;

	// Checks kept next to the gate they guard
	a_latch_needed: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.gated && !latch_ff) |=> (!accept_ff && refuse_ff))
		else $error("gated command accepted without latch");

	a_write_enable_cmd_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.write_enable_cmd && !busy_now) |=> (latch_ff && accept_ff))
		else $error("write enable did not set latch");

	a_done_clears: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(busy_now && op_done_in) |=> (!latch_ff && !busy_now))
		else $error("completion left latch or busy set");

	a_exempt_alternates: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && !busy_now && !latch_ff &&
		(cmd_in.opcode == fwp_pkg::OP_RP_V_ALT || cmd_in.opcode == fwp_pkg::OP_BANK_ALT))
		|=> accept_ff)
		else $error("exempt alternate opcode refused");

	a_protect_inhibit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.addr_check && range_hit) |=> (!accept_ff ##1 !busy_now))
		else $error("write into protected block accepted");

	a_chip_erase_bp: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.chip_erase && bp_ff != fwp_pkg::BP_NONE) |=> !accept_ff)
		else $error("chip erase accepted with protect bits set");

	a_sr_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.status_write && srlock_ff && !wp_n_in && !quad_ff)
		|=> ($stable(status_out[7:2]) && !accept_ff))
		else $error("locked status register changed");

	a_sr_open: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && cls.status_write && latch_ff && !busy_now && (!srlock_ff || wp_n_in))
		|=> (accept_ff && status_out[7:2] == $past(cmd_in.sr_data[7:2]) && busy_now))
		else $error("permitted status write not applied");

	a_discard_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(cmd_in.valid && no_latch && !busy_now) |=> ($stable(status_out[7:1]) && !busy_now))
		else $error("discarded command changed state");

	a_pin_function: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$changed(quad_ff) |-> (pin_func_enable_out == !quad_ff))
		else $error("pin function out of step with quad enable");

	a_top_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(bp_ff == 4'h1 && !top_bottom_select_in && cls.addr_check && latch_ff &&
		!busy_now && cmd_in.valid && eff_addr[25:16] == 10'h3FF) |=> !accept_ff)
		else $error("top block not protected by code one");
endmodule
`default_nettype wire

// File: test/fwp_host_model.sv
/*
 Far-side model: host controller issuing decoded instruction strobes,
 plus the array engine's completion pulse.
 Assumes the caller enters each task just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model (
	input  wire logic              clk_in,      // System clock
	output var  fwp_pkg::fwp_cmd_t cmd_out,     // Instruction strobe
	output var  logic              op_done_out  // Engine completion pulse
);
	// Idle at time zero
	initial
	begin
		cmd_out     = '0;
		op_done_out = 1'b0;
	end

	// One-cycle strobe; operands inverted after, so stale values never help
	task automatic send(input logic [7:0] op, input logic [31:0] a, input logic [7:0] sr);
		cmd_out = {1'b1, op, a, sr};
		@(posedge clk_in);
		#1;
		cmd_out = {1'b0, ~op, ~a, ~sr};
	endtask

	// Engine finishes the running operation
	task automatic done();
		op_done_out = 1'b1;
		@(posedge clk_in);
		#1;
		op_done_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: test/tb.sv
/*
 Self-checking bench for the write-permission gate.
 Assumes the host model drives strobes one delay after each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic              clk_sys = 1'b0;
	logic              rst     = 1'b1;
	logic              mode4b  = 1'b0;
	logic              wp_n    = 1'b1;
	logic              top_bottom_select     = 1'b0;
	logic              accept;
	logic              refuse;
	logic              latch;
	logic              busy;
	logic              quad;
	logic              pfe;
	logic [31:0]       acc_addr;
	logic [7:0]        status;
	logic              op_done;
	fwp_pkg::fwp_cmd_t cmd;
	int                fails = 0;
	int                samples_checked = 0;
	localparam logic [7:0] GATED [25] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E, 8'hD7,
		8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'h65, 8'h63, 8'h85, 8'h83, 8'h18, 8'hC5,
		8'h43, 8'h4A, 8'hFB, 8'hE1, 8'hFD, 8'hE3};
	localparam int PROT_N [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 768, 896, 960,
		992, 1024};

	always #4 clk_sys = ~clk_sys;

	fwp_host_model host (.clk_in(clk_sys), .cmd_out(cmd), .op_done_out(op_done));

	fwp_gate dut (
		.clk_sys_in            (clk_sys),
		.rst_in                (rst),
		.cmd_in                (cmd),
		.addr_mode_4b_in       (mode4b),
		.wp_n_in               (wp_n),
		.top_bottom_select_in  (top_bottom_select),
		.op_done_in            (op_done),
		.accept_out            (accept),
		.refuse_out            (refuse),
		.accepted_class_out    (),
		.accepted_addr_out     (acc_addr),
		.status_out            (status),
		.write_enable_latch_out(latch),
		.busy_out              (busy),
		.quad_enable_out       (quad),
		.pin_func_enable_out   (pfe)
	);

	// Expected protection from code, side and block
	function automatic logic prot_hit(input logic [3:0] c, input logic t, input logic [9:0] b);
		return t ? (int'(b) < PROT_N[c]) : (int'(b) >= 1024 - PROT_N[c]);
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Issue one command and check the one-cycle answer
	task automatic cmd_chk(input logic [7:0] op, input logic [31:0] a, input logic [7:0] sr,
		input logic acc);
		host.send(op, a, sr);
		chk("accept", accept, acc);
		chk("refuse", refuse, !acc);
		// One idle cycle so the strobe is never driven twice in one time step
		@(posedge clk_sys);
		#1;
	endtask

	// Return to idle with the latch clear
	task automatic settle();
		if (busy === 1'b1)
			host.done();
		else
			cmd_chk(fwp_pkg::OP_WR_DISABLE_DEF, '0, '0, 1'b1);
		chk("latch idle", latch, 1'b0);
		chk("busy idle", busy, 1'b0);
	endtask

	task automatic sr_write(input logic [7:0] sr, input logic acc);
		cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
		cmd_chk(fwp_pkg::OP_SR_WR, '0, sr, acc);
		settle();
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog, well beyond the thousand or so cycles the tests need
	initial
	begin
		#400us;
		fails++;
		test_done();
	end

	initial
	begin
		logic [31:0] a;
		logic [3:0]  bp;
		logic [9:0]  blk;
		int          n;
		void'($urandom(46750));
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chk("reset status", status, 8'h00);
		chk("reset pins", pfe, 1'b1);
		// Each opcode in GATED: refused without latch, accepted with it
		foreach (GATED[i])
		begin
			a      = $urandom();
			mode4b = 1'($urandom());
			cmd_chk(GATED[i], a, '0, 1'b0);
			chk("no side effect", {latch, busy, status}, 10'h000);
			cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
			chk("latch set", latch, 1'b1);
			cmd_chk(GATED[i], a, '0, 1'b1);
			chk("busy", busy, !(GATED[i] inside {8'h63, 8'h83, 8'hC5, 8'h4A, 8'hE1, 8'hFB}));
			if (GATED[i] == 8'h02)
				chk("addr", acc_addr, mode4b ? a : {8'h00, a[23:0]});
			if (GATED[i] == 8'h12)
				chk("addr 4b", acc_addr, a);
			settle();
		end
		// Exempt alternates need no latch
		cmd_chk(8'hC0, '0, '0, 1'b1);
		cmd_chk(8'h17, '0, '0, 1'b1);
		chk("latch still", latch, 1'b0);
		// Each protect code in turn, then random codes, with boundary or random blocks, then chip erase
		mode4b = 1'b1;
		for (int i = 0; i < 48; i++)
		begin
			bp  = (i < 16) ? 4'(i) : 4'($urandom());
			top_bottom_select = 1'($urandom());
			sr_write({2'b00, bp, 2'b00}, 1'b1);
			chk("protect code", status[5:2], bp);
			n   = PROT_N[bp];
			case (i % 4)
				0: blk = 10'(n);
				1: blk = 10'(n - 1);
				2: blk = 10'(1024 - n);
				default: blk = 10'($urandom());
			endcase
			a = {6'($urandom()), blk, 16'($urandom())};
			cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
			cmd_chk(fwp_pkg::OP_BE64, a, '0, !prot_hit(bp, top_bottom_select, blk));
			settle();
			cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
			cmd_chk(i[0] ? fwp_pkg::OP_CE_A : fwp_pkg::OP_CE_B, '0, '0, bp == 4'h0);
			settle();
		end
		// Corner: code one from the top guards only the last block
		sr_write(8'h04, 1'b1);
		top_bottom_select = 1'b0;
		cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
		cmd_chk(fwp_pkg::OP_BE64, 32'h03FF_0000, '0, 1'b0);
		settle();
		cmd_chk(fwp_pkg::OP_WR_ENABLE, '0, '0, 1'b1);
		cmd_chk(fwp_pkg::OP_BE64, 32'h03FE_0000, '0, 1'b1);
		settle();
		// Status lock against protect pin and quad enable
		sr_write(8'h80, 1'b1);
		wp_n = 1'b0;
		sr_write(8'h3C, 1'b0);
		chk("locked bits", status[7:2], 6'h20);
		wp_n = 1'b1;
		sr_write(8'hC0, 1'b1);
		chk("pins as data", pfe, 1'b0);
		chk("quad", quad, 1'b1);
		wp_n = 1'b0;
		sr_write(8'h00, 1'b1);
		chk("pins live", pfe, 1'b1);
		sr_write(8'h04, 1'b1);
		chk("free write", status[7:2], 6'h01);
		test_done();
	end
endmodule
`default_nettype wire
